// *** design/rea_rail_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module rea_rail_ctrl (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic vid_bus_clock_in,
    input wire logic vid_alert_ack_in,
    input wire logic main_rail_enable_in,
    input wire logic low_power_reset_n_in,
    input wire logic por_done_in,
    input wire logic fault_shutdown_in,
    input wire logic aux_rail_enable_in,
    input wire logic smb_alert_req_in,
    input wire rea_pkg::rea_duty_t duty_in,
    input wire rea_pkg::rea_sense_t sense_in,
    input wire rea_pkg::rea_mp0_t mp0_cfg_in,
    input wire rea_pkg::rea_mp1_t mp1_cfg_in,
    input wire rea_pkg::rea_mp2_t mp2_cfg_in,
    input wire logic multi_pin_0_in,
    output logic multi_pin_0_out,
    output logic multi_pin_0_oe_out,
    input wire logic multi_pin_1_in,
    output logic multi_pin_1_out,
    output logic multi_pin_1_oe_out,
    output logic multi_pin_2_out,
    output logic multi_pin_2_oe_out,
    output logic current_monitor_out,
    output logic main_phase1_pwm_out,
    output logic main_phase2_pwm_out,
    output logic main_phase3_pwm_out,
    output logic aux_phase_pwm_out,
    output logic main_rail_ready_out,
    output logic aux_rail_ready_out,
    output logic regulator_hot_n_out,
    output logic input_power_alert_n_out,
    output logic fault_out_one_out,
    output logic fault_out_two_out,
    output logic low_power_mode_out,
    output logic vid_status_alert_n_out,
    output logic vid_cmd_accept_out
);
    import rea_pkg::*;
    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic [1:0] en_sync_ff;
    logic [1:0] lpr_sync_ff;
    logic [1:0] mp0_sync_ff;
    logic [1:0] mp1_sync_ff;
    logic en_prev_ff;
    logic en_rise;
    rea_state_t state_ff;
    rea_state_t nxt_state;
    logic [11:0] ss_cnt_ff;
    logic fault_latch_ff;
    logic [7:0] pwm_cnt_ff;
    logic [3:0] pwm_ff;
    logic ready_ff;
    logic aux_ready_ff;
    logic hot_ff;
    logic palert_ff;
    logic status_tgl_ff;
    logic lpm_pin;
    logic low_power_req;
    logic main_dyn;
    logic aux_dyn;
    logic aux_en;
    logic running;
    // Link side
    logic [1:0] lrst_sync_ff;
    logic [2:0] ltgl_sync_ff;
    logic [1:0] lrdy_sync_ff;
    logic lalert_ff;
    function automatic logic duty_hit(input logic [7:0] cnt, input logic [7:0] duty);
        duty_hit = cnt < duty;
    endfunction
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rst_sync_ff <= SYNC_RST;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];
    // Pin synchronisers
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_sync_ff <= SYNC_RST;
            lpr_sync_ff <= 2'h3;
            mp0_sync_ff <= SYNC_RST;
            mp1_sync_ff <= SYNC_RST;
        end
        else if (ce_in)
        begin
            en_sync_ff <= {en_sync_ff[0], main_rail_enable_in};
            lpr_sync_ff <= {lpr_sync_ff[0], low_power_reset_n_in};
            mp0_sync_ff <= {mp0_sync_ff[0], multi_pin_0_in};
            mp1_sync_ff <= {mp1_sync_ff[0], multi_pin_1_in};
        end
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
            en_prev_ff <= 1'b0;
        else if (ce_in)
            en_prev_ff <= en_sync_ff[1];
    end
    assign en_rise = en_sync_ff[1] && !en_prev_ff;
    assign lpm_pin = (mp0_cfg_in == MP0_LPM) && mp0_sync_ff[1];
    assign low_power_req = !lpr_sync_ff[1] || lpm_pin;
    assign main_dyn = !(((mp0_cfg_in == MP0_MAIN_DYN) && !mp0_sync_ff[1])
        || ((mp1_cfg_in == MP1_MAIN_DYN) && !mp1_sync_ff[1]));
    assign aux_dyn = !(((mp0_cfg_in == MP0_AUX_DYN) && !mp0_sync_ff[1])
        || ((mp1_cfg_in == MP1_AUX_DYN) && !mp1_sync_ff[1]));
    assign aux_en = (mp1_cfg_in == MP1_AUX_EN) ? mp1_sync_ff[1] : aux_rail_enable_in;
    // Latched fault: set only in ST_SOFT or ST_ON, so a fault at the re-enable edge loses to the clear
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
            fault_latch_ff <= 1'b0;
        else if (ce_in)
        begin
            if (fault_shutdown_in && (state_ff == ST_SOFT || state_ff == ST_ON))
                fault_latch_ff <= 1'b1;
            else if (en_rise)
                fault_latch_ff <= 1'b0;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF:
                if (en_sync_ff[1] && por_done_in && !fault_latch_ff)
                    nxt_state = ST_SOFT;
            ST_SOFT:
                if (fault_shutdown_in)
                    nxt_state = ST_FAULT;
                else if (!en_sync_ff[1])
                    nxt_state = ST_OFF;
                else if (ss_cnt_ff == SS_CYCLES)
                    nxt_state = ST_ON;
            ST_ON:
                if (fault_shutdown_in)
                    nxt_state = ST_FAULT;
                else if (!en_sync_ff[1])
                    nxt_state = ST_OFF;
            ST_FAULT:
                if (en_rise && por_done_in)
                    nxt_state = ST_SOFT;
            ST_LOWPWR:
                if (!low_power_req)
                    nxt_state = ST_OFF;
            default:
                nxt_state = ST_OFF;
        endcase
        if (low_power_req)
            nxt_state = ST_LOWPWR;
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= ST_OFF;
        else if (ce_in)
            state_ff <= nxt_state;
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
            ss_cnt_ff <= SS_CNT_RST;
        else if (ce_in)
        begin
            if (state_ff != ST_SOFT)
                ss_cnt_ff <= SS_CNT_RST;
            else if (ss_cnt_ff != SS_CYCLES)
                ss_cnt_ff <= ss_cnt_ff + 12'h001;
        end
    end

    assign running = (state_ff == ST_SOFT) || (state_ff == ST_ON);
    // Four PWM channels on one shared ramp
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwm_cnt_ff <= PWM_CNT_RST;
            pwm_ff <= 4'h0;
        end
        else if (ce_in)
        begin
            pwm_cnt_ff <= running ? pwm_cnt_ff + 8'h01 : PWM_CNT_RST;
            pwm_ff[0] <= running && duty_hit(pwm_cnt_ff, duty_in.ph1);
            pwm_ff[1] <= running && main_dyn && duty_hit(pwm_cnt_ff, duty_in.ph2);
            pwm_ff[2] <= running && main_dyn && duty_hit(pwm_cnt_ff, duty_in.ph3);
            pwm_ff[3] <= running && aux_en && aux_dyn
                && duty_hit(pwm_cnt_ff, duty_in.aux);
        end
    end

    // Status outputs and change toggle
    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_ff <= 1'b0;
            aux_ready_ff <= 1'b0;
            hot_ff <= 1'b0;
            palert_ff <= 1'b0;
            status_tgl_ff <= 1'b0;
        end
        else if (ce_in)
        begin
            ready_ff <= (nxt_state == ST_ON);
            aux_ready_ff <= (nxt_state == ST_ON) && aux_en;
            hot_ff <= sense_in.temp >= sense_in.temp_max;
            palert_ff <= sense_in.pwr >= sense_in.pwr_max;
            if ((ready_ff != (nxt_state == ST_ON))
                || (hot_ff != (sense_in.temp >= sense_in.temp_max)))
                status_tgl_ff <= !status_tgl_ff;
        end
    end

    assign main_phase1_pwm_out = pwm_ff[0];
    assign main_phase2_pwm_out = pwm_ff[1];
    assign main_phase3_pwm_out = pwm_ff[2];
    assign aux_phase_pwm_out = pwm_ff[3];
    assign main_rail_ready_out = ready_ff;
    assign aux_rail_ready_out = aux_ready_ff;
    assign regulator_hot_n_out = !hot_ff;
    assign input_power_alert_n_out = !palert_ff;
    assign fault_out_one_out = fault_latch_ff;
    assign fault_out_two_out = hot_ff || palert_ff;
    assign low_power_mode_out = (state_ff == ST_LOWPWR);

    // Multi-purpose pin routing
    always_comb
    begin
        multi_pin_0_out = 1'b0;
        multi_pin_0_oe_out = 1'b1;
        case (mp0_cfg_in)
            MP0_AUX_RDY: multi_pin_0_out = aux_ready_ff;
            MP0_FAULT_OUT_ONE: multi_pin_0_out = fault_out_one_out;
            MP0_FAULT_OUT_TWO: multi_pin_0_out = fault_out_two_out;
            default: multi_pin_0_oe_out = 1'b0;
        endcase
    end

    always_comb
    begin
        multi_pin_1_out = 1'b0;
        multi_pin_1_oe_out = 1'b1;
        case (mp1_cfg_in)
            MP1_AUX_RDY: multi_pin_1_out = aux_ready_ff;
            MP1_FAULT_OUT_ONE: multi_pin_1_out = fault_out_one_out;
            MP1_FAULT_OUT_TWO: multi_pin_1_out = fault_out_two_out;
            MP1_SMB_ALERT: multi_pin_1_oe_out = smb_alert_req_in;
            default: multi_pin_1_oe_out = 1'b0;
        endcase
    end

    always_comb
    begin
        multi_pin_2_out = 1'b0;
        multi_pin_2_oe_out = 1'b0;
        current_monitor_out = 1'b0;
        case (mp2_cfg_in)
            MP2_FAULT_OUT_TWO:
            begin
                multi_pin_2_out = fault_out_two_out;
                multi_pin_2_oe_out = 1'b1;
            end
            MP2_SMB_ALERT: multi_pin_2_oe_out = smb_alert_req_in;
            MP2_CURRENT_MONITOR_OUT: current_monitor_out = 1'b1;
            default: multi_pin_2_oe_out = 1'b0;
        endcase
    end

    // Link clock domain
    always_ff @(posedge vid_bus_clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            lrst_sync_ff <= SYNC_RST;
        else
            lrst_sync_ff <= {lrst_sync_ff[0], 1'b1};
    end

    always_ff @(posedge vid_bus_clock_in or negedge lrst_sync_ff[1])
    begin
        if (!lrst_sync_ff[1])
        begin
            ltgl_sync_ff <= 3'h0;
            lrdy_sync_ff <= SYNC_RST;
        end
        else
        begin
            ltgl_sync_ff <= {ltgl_sync_ff[1:0], status_tgl_ff};
            lrdy_sync_ff <= {lrdy_sync_ff[0], ready_ff};
        end
    end

    always_ff @(posedge vid_bus_clock_in or negedge lrst_sync_ff[1])
    begin
        if (!lrst_sync_ff[1])
            lalert_ff <= 1'b0;
        else if (ltgl_sync_ff[2] != ltgl_sync_ff[1])
            lalert_ff <= 1'b1;
        else if (vid_alert_ack_in)
            lalert_ff <= 1'b0;
    end

    assign vid_status_alert_n_out = !lalert_ff;
    assign vid_cmd_accept_out = lrdy_sync_ff[1];
endmodule

`default_nettype wire

// *** design/rea_pkg.sv ***
package rea_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int SOFT_START_US = 100;
    localparam int SS_CYC_INT = (CLK_HZ / 1_000_000) * SOFT_START_US;
    localparam logic [11:0] SS_CYCLES = 12'(SS_CYC_INT);
    localparam logic [11:0] SS_CNT_RST = 12'h000;
    localparam logic [7:0] PWM_CNT_RST = 8'h00;
    localparam logic [1:0] SYNC_RST = 2'h0;

    typedef enum logic [4:0] {
        ST_OFF = 5'h01,
        ST_SOFT = 5'h02,
        ST_ON = 5'h04,
        ST_FAULT = 5'h08,
        ST_LOWPWR = 5'h10
    } rea_state_t;

    typedef enum logic [2:0] {
        MP0_AUX_RDY = 3'h0,
        MP0_FAULT_OUT_ONE = 3'h1,
        MP0_FAULT_OUT_TWO = 3'h2,
        MP0_MAIN_DYN = 3'h3,
        MP0_AUX_DYN = 3'h4,
        MP0_LPM = 3'h5
    } rea_mp0_t;

    typedef enum logic [2:0] {
        MP1_AUX_EN = 3'h0,
        MP1_AUX_RDY = 3'h1,
        MP1_FAULT_OUT_ONE = 3'h2,
        MP1_FAULT_OUT_TWO = 3'h3,
        MP1_MAIN_DYN = 3'h4,
        MP1_AUX_DYN = 3'h5,
        MP1_SMB_ALERT = 3'h6
    } rea_mp1_t;

    typedef enum logic [1:0] {
        MP2_FAULT_OUT_TWO = 2'h0,
        MP2_SMB_ALERT = 2'h1,
        MP2_CURRENT_MONITOR_OUT = 2'h2
    } rea_mp2_t;

    typedef struct packed {
        logic [7:0] ph1;
        logic [7:0] ph2;
        logic [7:0] ph3;
        logic [7:0] aux;
    } rea_duty_t;

    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] temp_max;
        logic [7:0] pwr;
        logic [7:0] pwr_max;
    } rea_sense_t;
endpackage

// *** testbench/rea_chk_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module rea_chk
    import rea_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic vid_bus_clock_in,
    input wire logic vid_alert_ack_in,
    input wire logic main_rail_enable_in,
    input wire logic low_power_reset_n_in,
    input wire logic fault_shutdown_in,
    input wire logic smb_alert_req_in,
    input wire rea_pkg::rea_sense_t sense_in,
    input wire rea_pkg::rea_mp1_t mp1_cfg_in,
    input wire rea_pkg::rea_mp2_t mp2_cfg_in,
    input wire logic multi_pin_1_out,
    input wire logic multi_pin_1_oe_out,
    input wire logic multi_pin_2_oe_out,
    input wire logic current_monitor_out,
    input wire logic main_rail_ready_out,
    input wire logic regulator_hot_n_out,
    input wire logic input_power_alert_n_out,
    input wire logic low_power_mode_out,
    input wire logic vid_status_alert_n_out
);
    logic [1:0] rc_ff;
    logic run;
    // Core reset lags the pin by the sync stages
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rc_ff <= 2'h0;
        else if (rc_ff != 2'h3)
            rc_ff <= rc_ff + 2'h1;
    end
    assign run = rc_ff == 2'h3 && ce_in;
    property p_hot;
        @(posedge clk_in) disable iff (!rst_n_in)
        run && sense_in.temp >= sense_in.temp_max |=> !regulator_hot_n_out;
    endproperty
    a_hot: assert property (p_hot) else $error("hot flag missing");
    property p_pwr;
        @(posedge clk_in) disable iff (!rst_n_in)
        run && sense_in.pwr >= sense_in.pwr_max |=> !input_power_alert_n_out;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power alert missing");
    property p_flt;
        @(posedge clk_in) disable iff (!rst_n_in)
        run && fault_shutdown_in && main_rail_ready_out |=> !main_rail_ready_out;
    endproperty
    a_flt: assert property (p_flt) else $error("ready kept on fault");
    property p_lp;
        @(posedge clk_in) disable iff (!rst_n_in)
        (run && !low_power_reset_n_in) [*4] |=> low_power_mode_out && !main_rail_ready_out;
    endproperty
    a_lp: assert property (p_lp) else $error("low power not entered");
    property p_en;
        @(posedge clk_in) disable iff (!rst_n_in)
        (ce_in && !main_rail_enable_in) [*4] |=> !main_rail_ready_out;
    endproperty
    a_en: assert property (p_en) else $error("ready without enable");
    property p_mp2;
        @(posedge clk_in) disable iff (!rst_n_in)
        mp2_cfg_in == MP2_CURRENT_MONITOR_OUT |-> current_monitor_out && !multi_pin_2_oe_out;
    endproperty
    a_mp2: assert property (p_mp2) else $error("pin 2 monitor wrong");
    property p_smb;
        @(posedge clk_in) disable iff (!rst_n_in)
        mp1_cfg_in == MP1_SMB_ALERT |-> !multi_pin_1_out
            && multi_pin_1_oe_out == smb_alert_req_in;
    endproperty
    a_smb: assert property (p_smb) else $error("pin 1 alert wrong");
    property p_alt;
        @(posedge vid_bus_clock_in) disable iff (!rst_n_in)
        !vid_status_alert_n_out && !vid_alert_ack_in |=> !vid_status_alert_n_out;
    endproperty
    a_alt: assert property (p_alt) else $error("alert dropped early");
    c_rdy: cover property (@(posedge clk_in) $rose(main_rail_ready_out));
    c_lp: cover property (@(posedge clk_in) $rose(low_power_mode_out));
    c_alt: cover property (@(posedge vid_bus_clock_in) $fell(vid_status_alert_n_out));
endmodule
`default_nettype wire

// *** testbench/rea_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rea_host_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic alert_n_in,
    input wire logic slow_in,
    output logic ack_out
);
    logic [2:0] wait_ff;
    // Host acknowledges an alert promptly or late
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wait_ff <= 3'h0;
            ack_out <= 1'b0;
        end
        else if (alert_n_in)
        begin
            wait_ff <= 3'h0;
            ack_out <= 1'b0;
        end
        else if (wait_ff == (slow_in ? 3'h6 : 3'h1))
            ack_out <= 1'b1;
        else
            wait_ff <= wait_ff + 3'h1;
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rea_pkg::*;
    logic clk_in, vid_bus_clock_in, rst_n_in, ce_in, vid_alert_ack_in, main_rail_enable_in;
    logic low_power_reset_n_in, por_done_in, fault_shutdown_in, aux_rail_enable_in;
    logic smb_alert_req_in, mp0_ext, slow, multi_pin_0_out, multi_pin_0_oe_out;
    logic multi_pin_1_out, multi_pin_1_oe_out, multi_pin_2_out, multi_pin_2_oe_out;
    logic current_monitor_out, main_phase1_pwm_out, main_phase2_pwm_out;
    logic main_phase3_pwm_out, aux_phase_pwm_out, main_rail_ready_out, aux_rail_ready_out;
    logic regulator_hot_n_out, input_power_alert_n_out, fault_out_one_out;
    logic fault_out_two_out, low_power_mode_out, vid_status_alert_n_out, vid_cmd_accept_out;
    rea_duty_t duty_in;
    rea_sense_t sense_in;
    rea_mp0_t mp0_cfg_in;
    rea_mp1_t mp1_cfg_in;
    rea_mp2_t mp2_cfg_in;
    wire logic multi_pin_0_in;
    wire logic multi_pin_1_in;
    int n_errors, num_checks, n, n_alert;
    int cnt[4];
    assign multi_pin_0_in = multi_pin_0_oe_out ? multi_pin_0_out : mp0_ext;
    assign multi_pin_1_in = multi_pin_1_oe_out ? multi_pin_1_out : 1'b1;
    rea_rail_ctrl rea_rail_ctrl_inst (.*);
    rea_host_model rea_host_model_inst (.clk_in(vid_bus_clock_in), .rst_n_in(rst_n_in),
        .alert_n_in(vid_status_alert_n_out), .slow_in(slow), .ack_out(vid_alert_ack_in));
    initial
    begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    initial
    begin
        vid_bus_clock_in = 1'b0;
        #13;
        forever #40 vid_bus_clock_in = ~vid_bus_clock_in;
    end
    always @(negedge vid_status_alert_n_out) n_alert++;
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic ss();
        n = 0;
        while (main_rail_ready_out !== 1'b1 && n < 1100)
        begin
            cyc(1);
            n++;
        end
        chk(n >= SS_CYCLES - 8 && n <= SS_CYCLES + 8, 1'b1);
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        #1_500_000;
        n_errors++;
        wrap_up();
    end
    initial
    begin
        {rst_n_in, main_rail_enable_in, por_done_in, fault_shutdown_in} = 4'h0;
        {ce_in, low_power_reset_n_in, aux_rail_enable_in} = 3'h7;
        {smb_alert_req_in, mp0_ext, slow} = 3'h0;
        duty_in = 32'h0;
        sense_in = 32'h10FF10FF;
        mp0_cfg_in = MP0_AUX_RDY;
        mp1_cfg_in = MP1_FAULT_OUT_ONE;
        mp2_cfg_in = MP2_FAULT_OUT_TWO;
        n = $urandom(88);
        cyc(2);
        rst_n_in <= 1'b1;
        cyc(4);
        chk({main_rail_ready_out, regulator_hot_n_out, vid_status_alert_n_out}, 3'h3);
        main_rail_enable_in <= 1'b1;
        cyc(30);
        chk(main_rail_ready_out, 1'b0);
        por_done_in <= 1'b1;
        ss();
        cyc(10);
        chk({vid_cmd_accept_out, vid_status_alert_n_out, n_alert == 1}, 3'h7);
        slow <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            sense_in <= (i == 0) ? 32'h5555AAAA : $urandom;
            cyc(3);
            chk(regulator_hot_n_out, sense_in.temp < sense_in.temp_max);
            chk(input_power_alert_n_out, sense_in.pwr < sense_in.pwr_max);
        end
        sense_in <= 32'h10FF10FF;
        cyc(40);
        chk({vid_status_alert_n_out, n_alert > 1}, 2'h3);
        duty_in <= $urandom;
        cnt = '{default: 0};
        cyc(3);
        repeat (256)
        begin
            cnt[0] += main_phase1_pwm_out;
            cnt[1] += main_phase2_pwm_out;
            cnt[2] += main_phase3_pwm_out;
            cnt[3] += aux_phase_pwm_out;
            cyc(1);
        end
        chk(cnt[0], duty_in.ph1);
        chk(cnt[1], duty_in.ph2);
        chk(cnt[2], duty_in.ph3);
        chk(cnt[3], duty_in.aux);
        fault_shutdown_in <= 1'b1;
        cyc(1);
        fault_shutdown_in <= 1'b0;
        cyc(22);
        chk({main_rail_ready_out, fault_out_one_out, main_phase1_pwm_out}, 3'h2);
        main_rail_enable_in <= 1'b0;
        cyc(5);
        main_rail_enable_in <= 1'b1;
        cyc(5);
        chk(fault_out_one_out, 1'b0);
        ss();
        low_power_reset_n_in <= 1'b0;
        cyc(6);
        chk({low_power_mode_out, main_rail_ready_out}, 2'h2);
        low_power_reset_n_in <= 1'b1;
        cyc(5);
        chk(low_power_mode_out, 1'b0);
        ss();
        for (int i = 0; i < 7; i++)
        begin
            mp0_cfg_in <= rea_mp0_t'(i % 6);
            mp1_cfg_in <= rea_mp1_t'(i);
            mp2_cfg_in <= rea_mp2_t'(i % 3);
            smb_alert_req_in <= 1'($urandom);
            cyc(2);
            chk(multi_pin_0_oe_out, i % 6 < 3);
            chk(multi_pin_1_oe_out, i == 6 ? smb_alert_req_in : i > 0 && i < 4);
            chk(multi_pin_2_oe_out, i % 3 == 1 ? smb_alert_req_in : i % 3 == 0);
        end
        ce_in <= 1'b0;
        main_rail_enable_in <= 1'b0;
        cyc(6);
        chk(main_rail_ready_out, 1'b1);
        ce_in <= 1'b1;
        cyc(5);
        chk(main_rail_ready_out, 1'b0);
        mp0_cfg_in <= MP0_LPM;
        mp0_ext <= 1'b1;
        cyc(6);
        chk(low_power_mode_out, 1'b1);
        wrap_up();
    end
endmodule
bind rea_rail_ctrl rea_chk rea_chk_inst (.*);
`default_nettype wire
